// >>> pmr_sequencer.sv
/*
 * Power-mode, reset and boot-strap sequencer.
 * Assumes the host drives reset, wake and handshake pins asynchronously;
 * commands arrive as one-cycle pulses from core logic on core_clk.
 */
// Overview of operation
// - Boot on supply rise or any reset
// - Banner pulse after boot in command mode
// - Active and Standby switch automatically
// - Standby keeps links, wakes instantly
// - Auto clock scaling lowers clocks in Standby when enabled
// - No Sleep state; only Stop is manual
// - Stop halts, drops links, clears RAM
// - Wake from Stop always reboots fully
// - Stop only on request, method chosen first
// - Handshake method follows DSR input
// - Halt with GPI follows that input
// - Halt with timer wakes after delay
// - Low reset pin resets, pulled up
// - Reset command performs software reboot
// - Stop draws less than held reset
// - Boot-select 0 factory, 1 flash
// - Verbose strap 0 silent; later SPI select
// - Flash-voltage strap must be 1; later MISO
`timescale 1ns/1ns
module pmr_sequencer
    import pmr_pkg::*;
(
    input wire logic core_clk, // Core clock, 250 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic supply_good, // Main supply valid level (async)
    input wire logic reset_pin_n, // Hardware reset pin, pulled up (async)
    input wire logic sw_reset_cmd, // Reset command pulse
    input wire logic cmd_mode_cfg, // Start in command mode
    input wire logic clock_scaling_command, // Pulse: load auto_clock_scaling
    input wire logic clock_scaling_val, // Value for auto_clock_scaling
    input wire logic handshake_stop_select_command, // Pulse: select DSR method
    input wire logic halt_command, // Pulse: enter Stop via GPI or timer
    input wire logic halt_use_timer, // Halt uses timer, else GPI
    input wire logic [1:0] halt_gpi_sel, // Which wake input to follow
    input wire logic [TMR_W-1:0] halt_delay, // Timer delay in cycles
    input wire logic dsr_pin, // UART DSR from host (async)
    input wire logic [WK_N-1:0] wake_pin, // Wake-capable inputs (async)
    input wire logic activity, // Any interface or radio activity
    input wire logic strap_boot_sel, // Boot-select strap pin (async)
    input wire logic strap_verbose, // Verbose strap, later SPI select (async)
    input wire logic strap_flash_v, // Flash-voltage strap, later MISO (async)
    output logic boot_done, // Booted and running
    output logic banner_pulse, // Emit boot banner on UART
    output logic verbose_en, // Print boot information
    output logic factory_boot, // Factory boot selected
    output logic flash_1v8, // Internal flash at 1.8 V
    output logic spi_pins_en, // Strap pins now act as SPI pins
    output logic standby, // In Standby
    output logic clk_reduce, // Lower internal clocks
    output logic stopped, // In Stop: all functions halted
    output logic links_drop, // Drop all connections
    output logic ram_clear // Discard system RAM
);
    // Whole state of the module
    typedef struct packed {
        pmr_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [TMR_W-1:0] tmr;
        logic [1:0] method;
        logic [1:0] gsel;
        // Six single pins plus the wake inputs pass through the same two stages
        logic [5+WK_N:0] s1; // First sync stage
        logic [5+WK_N:0] s2; // Second sync stage
        logic afa;
        logic verbose;
        logic factory;
        logic fv;
        logic boot_done;
        logic banner;
        logic standby;
        logic stopped;
        logic drop;
        logic ram_clr;
        logic clk_red; // Registered clock-reduce request
    } pmr_regs_t;

    pmr_regs_t cur_ff;
    pmr_regs_t nxt_cur;
    logic rst_src; // Low reset pin or supply fault
    logic dsr_s; // Synchronised DSR
    logic wk_sel; // Selected synchronised wake input

    // Second stage bits: {supply, reset_n, dsr, boot, verbose, flash, wake}
    // Supply sits at the top bit, the reset line just below it, then the handshake line.
    // A supply dip and a low reset line are treated alike: both hold the core in reset
    // until the synchronised level has been high for a full edge.
    assign rst_src = !cur_ff.s2[5+WK_N] || !cur_ff.s2[4+WK_N];
    assign dsr_s = cur_ff.s2[3+WK_N];
    assign wk_sel = cur_ff.s2[cur_ff.gsel];

    // Next-state logic for the whole sequencer
    always_comb
    begin
        nxt_cur = cur_ff;
        // Two-stage synchroniser; only s2 is read by logic
        // The straps share these flops, so they cost two cycles of latency like the rest
        nxt_cur.s1 = {supply_good, reset_pin_n, dsr_pin, strap_boot_sel, strap_verbose,
                      strap_flash_v, wake_pin};
        nxt_cur.s2 = cur_ff.s1;
        nxt_cur.banner = 1'b0;
        nxt_cur.drop = 1'b0;
        nxt_cur.ram_clr = 1'b0;
        if (clock_scaling_command)
        begin
            nxt_cur.afa = clock_scaling_val;
        end
        if (handshake_stop_select_command)
        begin
            nxt_cur.method = STOP_DSR;
        end
        // Cheaper than a held reset: Stop gates everything off
        case (cur_ff.st)
            ST_RESET:
            begin
                nxt_cur.boot_done = 1'b0;
                nxt_cur.stopped = 1'b0;
                nxt_cur.standby = 1'b0;
                nxt_cur.method = STOP_NONE;
                if (!rst_src)
                begin
                    // Straps caught once at release, held until next reset
                    nxt_cur.factory = !cur_ff.s2[2+WK_N];
                    nxt_cur.verbose = cur_ff.s2[1+WK_N];
                    nxt_cur.fv = cur_ff.s2[WK_N];
                    nxt_cur.cnt = BOOT_CNT;
                    nxt_cur.st = ST_BOOT;
                end
            end
            ST_BOOT:
            begin
                // Fixed boot length; halt and pins other than reset are ignored here, scaling and handshake-select commands still load
                if (cur_ff.cnt == CNT_ZERO)
                begin
                    nxt_cur.boot_done = 1'b1;
                    nxt_cur.banner = cmd_mode_cfg;
                    nxt_cur.cnt = IDLE_CNT;
                    nxt_cur.st = ST_ACTIVE;
                end
                else
                begin
                    nxt_cur.cnt = cur_ff.cnt - 16'h0001;
                end
            end
            ST_ACTIVE, ST_STANDBY:
            begin
                // Idle timeout takes the core to Standby; activity returns at once
                if (activity)
                begin
                    nxt_cur.cnt = IDLE_CNT;
                    nxt_cur.standby = 1'b0;
                    nxt_cur.st = ST_ACTIVE;
                end
                else if (cur_ff.cnt == CNT_ZERO)
                begin
                    nxt_cur.standby = 1'b1;
                    nxt_cur.st = ST_STANDBY;
                end
                else
                begin
                    nxt_cur.cnt = cur_ff.cnt - 16'h0001;
                end
                // Stop only on explicit request
                if (cur_ff.method == STOP_DSR && !dsr_s)
                begin
                    nxt_cur.st = ST_STOP;
                end
                else if (halt_command)
                begin
                    nxt_cur.method = halt_use_timer ? STOP_TMR : STOP_GPI;
                    nxt_cur.gsel = halt_gpi_sel;
                    nxt_cur.tmr = halt_delay;
                    nxt_cur.st = ST_STOP;
                end
                if (nxt_cur.st == ST_STOP)
                begin
                    nxt_cur.stopped = 1'b1;
                    nxt_cur.drop = 1'b1;
                    nxt_cur.ram_clr = 1'b1;
                    nxt_cur.standby = 1'b0;
                    nxt_cur.boot_done = 1'b0;
                end
            end
            ST_STOP:
            begin
                // Any wake goes through a full reboot, never a resume
                // The timer counts down only while stopped; zero is the wake condition
                if (cur_ff.method == STOP_TMR && cur_ff.tmr != TMR_ZERO)
                begin
                    nxt_cur.tmr = cur_ff.tmr - 32'h0000_0001;
                end
                if ((cur_ff.method == STOP_DSR && dsr_s) ||
                    (cur_ff.method == STOP_GPI && wk_sel) ||
                    (cur_ff.method == STOP_TMR && cur_ff.tmr == TMR_ZERO))
                begin
                    nxt_cur.st = ST_RESET;
                end
            end
            default:
            begin
                nxt_cur.st = ST_RESET;
            end
        endcase
        // Any reset source or reset command reboots from any state
        if (rst_src || sw_reset_cmd)
        begin
            nxt_cur.st = ST_RESET;
            nxt_cur.boot_done = 1'b0;
            nxt_cur.standby = 1'b0;
            nxt_cur.stopped = 1'b0;
            // A reset at the very end of boot must not leave a stray banner behind
            nxt_cur.banner = 1'b0;
        end
        // Clock reduction is registered so the output comes straight from a flop;
        // it is taken from the next Standby flag, so it adds no cycle of lag
        nxt_cur.clk_red = nxt_cur.standby && nxt_cur.afa;
    end

    // State register; reset loads ST_RESET and clears every other field, latched straps and sync stages included
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cur_ff <= '{st: ST_RESET, default: '0};
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    // Outputs straight from flip-flops; no Sleep state exists
    assign boot_done = cur_ff.boot_done;
    assign banner_pulse = cur_ff.banner;
    assign verbose_en = cur_ff.verbose;
    assign factory_boot = cur_ff.factory;
    assign flash_1v8 = cur_ff.fv;
    assign spi_pins_en = cur_ff.boot_done;
    assign standby = cur_ff.standby;
    // Clock reduction only ever applies in Standby, never while active
    assign clk_reduce = cur_ff.clk_red;
    assign stopped = cur_ff.stopped;
    assign links_drop = cur_ff.drop;
    assign ram_clear = cur_ff.ram_clr;

    // Banner only right after boot and in command mode
    property p_banner;
        @(posedge core_clk) disable iff (rst)
        banner_pulse |-> boot_done && $past(cur_ff.st) == ST_BOOT;
    endproperty
    a_banner: assert property (p_banner) else $error("banner outside boot end");

    // Entering Stop drops links and RAM, and needs a chosen method or a halt
    property p_stop_entry;
        @(posedge core_clk) disable iff (rst)
        $rose(stopped) |-> links_drop && ram_clear && ($past(cur_ff.method) != STOP_NONE || $past(halt_command));
    endproperty
    a_stop_entry: assert property (p_stop_entry) else $error("bad stop entry");

    // Leaving Stop lands in the reset state, never back in Active
    property p_wake_reboot;
        @(posedge core_clk) disable iff (rst)
        (cur_ff.st == ST_STOP && nxt_cur.st != ST_STOP) |=> cur_ff.st == ST_RESET;
    endproperty
    a_wake_reboot: assert property (p_wake_reboot) else $error("stop exit not a reboot");

    // A synchronised low on the reset line forces reset on the next edge
    property p_reset_pin;
        @(posedge core_clk) disable iff (rst)
        !cur_ff.s2[4+WK_N] |=> cur_ff.st == ST_RESET && !boot_done;
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored");

    // The reset command wins over every other request
    property p_sw_reset;
        @(posedge core_clk) disable iff (rst)
        sw_reset_cmd |=> cur_ff.st == ST_RESET;
    endproperty
    a_sw_reset: assert property (p_sw_reset) else $error("reset command ignored");

    // Activity in Standby returns to Active on the very next edge
    property p_wake_active;
        @(posedge core_clk) disable iff (rst)
        (activity && standby && !sw_reset_cmd && !rst_src && !halt_command && cur_ff.method != STOP_DSR)
        |=> !standby && cur_ff.st == ST_ACTIVE;
    endproperty
    a_wake_active: assert property (p_wake_active) else $error("standby did not wake");

    // Reduced clocks only in the Standby state and only when enabled
    property p_scale;
        @(posedge core_clk) disable iff (rst)
        clk_reduce |-> cur_ff.afa && cur_ff.st == ST_STANDBY;
    endproperty
    a_scale: assert property (p_scale) else $error("clock reduced while disabled");

    // Latched strap results may change only when reset is left
    property p_straps_hold;
        @(posedge core_clk) disable iff (rst)
        (cur_ff.st != ST_RESET) |=> $stable(verbose_en) && $stable(factory_boot) && $stable(flash_1v8);
    endproperty
    a_straps_hold: assert property (p_straps_hold) else $error("strap changed after boot");
endmodule

// >>> pmr_pkg.sv
/*
 * Package for the power-mode, reset and boot-strap sequencer.
 * Holds state codes, stop-method codes and timing counts.
 * Assumes a 250 MHz core clock.
 */
package pmr_pkg;
    // Core clock period in picoseconds
    localparam int CLK_PERIOD_PS = 4000;
    // Boot sequence length in nanoseconds, then in cycles
    localparam int BOOT_TIME_NS = 400;
    localparam int BOOT_CYC = (BOOT_TIME_NS * 1000) / CLK_PERIOD_PS;
    // Idle cycles before dropping to Standby
    localparam int IDLE_CYC = 16;
    // Width of the wake timer and general counters
    localparam int TMR_W = 32;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] BOOT_CNT = CNT_W'(BOOT_CYC);
    localparam logic [CNT_W-1:0] IDLE_CNT = CNT_W'(IDLE_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [TMR_W-1:0] TMR_ZERO = 32'h0000_0000;
    // Number of wake-capable general inputs
    localparam int WK_N = 3;
    // Stop control methods
    localparam logic [1:0] STOP_NONE = 2'h0;
    localparam logic [1:0] STOP_DSR = 2'h1;
    localparam logic [1:0] STOP_GPI = 2'h2;
    localparam logic [1:0] STOP_TMR = 2'h3;
    // Power states, one-hot
    typedef enum logic [4:0] {
        ST_RESET = 5'h01,
        ST_BOOT = 5'h02,
        ST_ACTIVE = 5'h04,
        ST_STANDBY = 5'h08,
        ST_STOP = 5'h10
    } pmr_state_t;
endpackage

// >>> pmr_host_model.sv
/*
 * Host-side model for the power-mode sequencer: reset, handshake, wake and strap pins.
 * Assumes the bench sets its control levels just after a core clock edge.
 */
`timescale 1ns/1ns
module pmr_host_model
    import pmr_pkg::*;
(
    input wire logic pull_rst, // Host pulls the reset line low
    input wire logic dsr_lvl, // Handshake level chosen by host
    input wire logic [WK_N-1:0] wake_lvl, // Wake input levels
    input wire logic strap_drv, // Straps driven instead of left floating
    input wire logic boot_val, // Driven boot-select level
    input wire logic verb_val, // Driven verbose level
    output logic reset_pin_n, // Reset line seen by the device
    output logic dsr_pin, // Handshake line
    output logic [WK_N-1:0] wake_pin, // Wake lines
    output logic strap_boot_sel, // Boot-select strap line
    output logic strap_verbose, // Verbose strap line
    output logic strap_flash_v // Flash-voltage strap line
);
    // Open-drain: only ever pulls low, the pull-up gives the high level
    assign reset_pin_n = pull_rst ? 1'b0 : 1'b1;
    // Host owns the handshake and wake lines outright
    assign dsr_pin = dsr_lvl;
    assign wake_pin = wake_lvl;
    // Undriven straps settle at their pull-up level
    assign strap_boot_sel = strap_drv ? boot_val : 1'b1;
    assign strap_verbose = strap_drv ? verb_val : 1'b1;
    // Never pulled low, so the flash always sees the low-voltage setting
    assign strap_flash_v = 1'b1;
endmodule

// >>> tb_power_mode_reset_bootstrap.sv
/*
 * Self-checking bench for the power-mode, reset and boot-strap sequencer.
 * Assumes pmr_pkg and pmr_host_model are compiled first.
 */
`timescale 1ns/1ns
module tb_power_mode_reset_bootstrap;
    import pmr_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, supply_good = 1'b1, sw_reset_cmd = 1'b0, cmd_mode_cfg = 1'b1;
    logic clock_scaling_command = 1'b0, clock_scaling_val = 1'b0, handshake_stop_select_command = 1'b0;
    logic halt_command = 1'b0, halt_use_timer = 1'b1, activity = 1'b1; // Commands and levels
    logic [1:0] halt_gpi_sel = 2'h0; // Wake input to follow
    logic [TMR_W-1:0] halt_delay = 32'h0000_0014; // Timer wake delay
    logic pull_rst = 1'b0, dsr_lvl = 1'b1, strap_drv = 1'b0, boot_val = 1'b1, verb_val = 1'b1; // Host controls
    logic [WK_N-1:0] wake_lvl = 3'h0; // Wake levels
    wire reset_pin_n, dsr_pin, strap_boot_sel, strap_verbose, strap_flash_v; // Host pins
    wire [WK_N-1:0] wake_pin; // Wake pins
    logic boot_done, banner_pulse, verbose_en, factory_boot, flash_1v8, spi_pins_en; // Outputs
    logic standby, clk_reduce, stopped, links_drop, ram_clear; // Outputs
    int mismatches = 0, num_checks = 0, seed = 91, k; // Tallies and seed
    logic [2:0] exp_q[$]; // Model: expected {banner, factory, verbose} per boot

    pmr_host_model HOST (.pull_rst(pull_rst), .dsr_lvl(dsr_lvl), .wake_lvl(wake_lvl), .strap_drv(strap_drv),
        .boot_val(boot_val), .verb_val(verb_val), .reset_pin_n(reset_pin_n), .dsr_pin(dsr_pin),
        .wake_pin(wake_pin), .strap_boot_sel(strap_boot_sel), .strap_verbose(strap_verbose),
        .strap_flash_v(strap_flash_v));
    pmr_sequencer DUT (.core_clk(core_clk), .rst(rst), .supply_good(supply_good), .reset_pin_n(reset_pin_n),
        .sw_reset_cmd(sw_reset_cmd), .cmd_mode_cfg(cmd_mode_cfg), .clock_scaling_command(clock_scaling_command),
        .clock_scaling_val(clock_scaling_val), .handshake_stop_select_command(handshake_stop_select_command),
        .halt_command(halt_command), .halt_use_timer(halt_use_timer), .halt_gpi_sel(halt_gpi_sel),
        .halt_delay(halt_delay), .dsr_pin(dsr_pin), .wake_pin(wake_pin), .activity(activity),
        .strap_boot_sel(strap_boot_sel), .strap_verbose(strap_verbose), .strap_flash_v(strap_flash_v),
        .boot_done(boot_done), .banner_pulse(banner_pulse), .verbose_en(verbose_en), .factory_boot(factory_boot),
        .flash_1v8(flash_1v8), .spi_pins_en(spi_pins_en), .standby(standby), .clk_reduce(clk_reduce),
        .stopped(stopped), .links_drop(links_drop), .ram_clear(ram_clear));

    // 250 MHz clock
    always #2 core_clk = ~core_clk;

    // Closing verdict, the single exit of the run
    task end_sim;
        if (mismatches == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Compare and tally
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Advance n cycles, landing just after the edge where inputs may change
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // One-cycle command pulse: 0 reset, 1 scaling, 2 handshake select, 3 halt
    task pulse(input int w);
        {sw_reset_cmd, clock_scaling_command, handshake_stop_select_command, halt_command} = 4'h8 >> w;
        cyc(1);
        {sw_reset_cmd, clock_scaling_command, handshake_stop_select_command, halt_command} = 4'h0;
    endtask

    // Bounded wait on boot_done, stopped or standby
    task wait_on(input int w, input int lim);
        int i;
        i = 0;
        while ((w == 0 ? boot_done : w == 1 ? stopped : standby) !== 1'b1 && i < lim)
        begin
            cyc(1);
            i++;
        end
        if (i >= lim)
        begin
            mismatches++;
            end_sim();
        end
    endtask

    // Reboot ends: banner and strap results, then straps must stay latched
    task wait_boot;
        logic eb, ev;
        logic [2:0] e;
        eb = strap_drv ? boot_val : 1'b1;
        ev = strap_drv ? verb_val : 1'b1;
        exp_q.push_back({cmd_mode_cfg, ~eb, ev});
        wait_on(0, 400);
        e = exp_q.pop_front();
        chk(banner_pulse, e[2]);
        chk(factory_boot, e[1]);
        chk(verbose_en, e[0]);
        chk({flash_1v8, spi_pins_en}, 2'h3);
        strap_drv = 1'b1;
        {boot_val, verb_val} = ~{eb, ev};
        cyc(4);
        chk({factory_boot, verbose_en}, {~eb, ev});
    endtask

    // Main sequence
    initial
    begin
        cyc(10);
        rst = 1'b0;
        cyc(2);
        pulse(3);
        cyc(2);
        chk(stopped, 1'b0);
        wait_boot();
        // Idle drops to standby; scaling follows its setting
        for (k = 0; k < 2; k++)
        begin
            clock_scaling_val = k[0];
            pulse(1);
            activity = 1'b0;
            wait_on(2, 60);
            chk(clk_reduce, k[0]);
            activity = 1'b1;
            cyc(2);
            chk({standby, clk_reduce, stopped}, 3'h0);
        end
        // Handshake line ignored until its method is selected
        dsr_lvl = 1'b0;
        cyc(8);
        chk(stopped, 1'b0);
        dsr_lvl = 1'b1;
        cyc(4);
        pulse(2);
        dsr_lvl = 1'b0;
        wait_on(1, 12);
        chk(boot_done, 1'b0);
        dsr_lvl = 1'b1;
        wait_boot();
        // Timed halt with a random delay
        halt_use_timer = 1'b1;
        halt_delay = 32'h0000_000a + ($random(seed) & 32'h0000_001f);
        pulse(3);
        chk({stopped, links_drop, ram_clear}, 3'h7);
        cyc(int'(halt_delay));
        chk(stopped, 1'b1);
        cyc(2);
        chk({stopped, boot_done}, 2'h0);
        wait_boot();
        // Halt following each wake input, random straps
        for (k = 0; k < WK_N; k++)
        begin
            {boot_val, verb_val} = 2'($random(seed));
            cmd_mode_cfg = k[0];
            halt_use_timer = 1'b0;
            halt_gpi_sel = k[1:0];
            pulse(3);
            cyc(6);
            chk(stopped, 1'b1);
            wake_lvl[k] = 1'b1;
            wait_boot();
            wake_lvl = 3'h0;
        end
        // Software reset, reset pin and supply drop all reboot
        pulse(0);
        cyc(3);
        chk(boot_done, 1'b0);
        wait_boot();
        pull_rst = 1'b1;
        cyc(6);
        chk(boot_done, 1'b0);
        pull_rst = 1'b0;
        wait_boot();
        supply_good = 1'b0;
        cyc(6);
        chk(boot_done, 1'b0);
        supply_good = 1'b1;
        wait_boot();
        end_sim();
    end
endmodule
